// ===== design/fflr_top.sv
// Sticky fault event register with its serial read path.
// Assumes events come from logic on clk; SCL and SDA come from the pins.
`default_nettype none

module fflr_top #(
    parameter int         HW_RESET_CYCLES = fflr_pkg::HW_RESET_CYCLES,
    parameter logic [6:0] DEV_ADDR        = fflr_pkg::DEV_ADDR_DEFAULT
) (
    // Control clock and reset.
    input  wire logic                clk,
    input  wire logic                rst_n,
    // Fault events from the protection logic.
    input  wire fflr_pkg::fflr_evt_s events,
    // Serial link pins.
    input  wire logic                scl,
    input  wire logic                sda_in,
    output logic                     sda_out,
    output logic                     sda_drive_n,
    // State toward the rest of the device.
    output logic                     link_hw_reset,
    output logic [7:0]               fault_event_latch
);

    // Control clock domain.
    logic [fflr_pkg::PEAK_CNT_W-1:0] peak_run;
    logic                            peak_persist;
    logic [7:0]                      set_vec;
    logic [7:0]                      report;
    logic [2:0]                      xs;
    logic                            scl_s;
    logic                            hold_s;
    logic                            done_s;
    logic                            hold_d;
    logic                            done_d;
    logic                            done_pulse;
    logic                            hw_reset;
    logic                            link_clear_req;

    // Link clock domain.
    fflr_pkg::fflr_link_e            state;
    logic [fflr_pkg::BIT_CNT_W-1:0]  cnt;
    logic [7:0]                      shift;
    logic [7:0]                      rx_next;
    logic [7:0]                      ptr;
    logic [7:0]                      tx;
    logic                            ack_en;
    logic                            rw;
    logic                            hold;
    logic                            done_tog;
    logic                            start_tog;
    logic                            start_seen;
    logic                            sda_pull;

    // Link state brought over as levels and toggles.
    fflr_sync #(
        .WIDTH (3)
    ) u_to_ctrl (
        .clk (clk),
        .d   ({scl, hold, done_tog}),
        .q   (xs)
    );

    assign scl_s  = xs[2];
    assign hold_s = xs[1];
    assign done_s = xs[0];

    // Hold-low detector on the synchronised serial clock.
    fflr_low_timer #(
        .CYCLES (HW_RESET_CYCLES)
    ) u_low_timer (
        .clk      (clk),
        .rst_n    (rst_n),
        .line_low (!scl_s),
        .expired  (hw_reset)
    );

    assign link_hw_reset = hw_reset;

    // Registered so the link side sees no glitch from the gate. The link
    // clock stands still between frames, so a synchronised copy would never
    // take effect; the link logic uses this level as its asynchronous reset.
    // Limitation: the host must leave the link idle for a few control
    // cycles after reset is released.
    always_ff @(posedge clk) begin
        link_clear_req <= !rst_n || hw_reset;
    end

    // Delayed copies find the read-done toggle and stretch the freeze.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            done_d <= done_s;
            hold_d <= 1'b0;
        end else begin
            done_d <= done_s;
            hold_d <= hold_s;
        end
    end

    assign done_pulse = done_s ^ done_d;

    // Counts consecutive cycles of peak current hit; saturates at target.
    always_ff @(posedge clk) begin
        if (!rst_n || hw_reset || !events.peak_current) begin
            peak_run <= '0;
        end else if (!peak_persist) begin
            peak_run <= peak_run + 1'b1;
        end
    end

    // A single hit never reaches the target, so it is not recorded.
    assign peak_persist = events.peak_current &&
        (peak_run ==
         fflr_pkg::PEAK_CNT_W'(fflr_pkg::PEAK_PERSIST_CYCLES - 1));

    // Event vector in register bit order; unused bits never set.
    always_comb begin
        set_vec = fflr_pkg::FAULT_EVENT_LATCH_RESET;
        set_vec[fflr_pkg::BIT_STARTUP_TIMEOUT] =
            events.startup_timeout;
        set_vec[fflr_pkg::BIT_INPUT_UNDERVOLTAGE] =
            events.input_undervoltage_lockout;
        set_vec[fflr_pkg::BIT_OVER_TEMP] = events.over_temp;
        set_vec[fflr_pkg::BIT_OUTPUT_SHORT] = events.output_short;
        set_vec[fflr_pkg::BIT_PEAK_CURRENT] = peak_persist;
    end

    // The sticky register. A read clears only what it returned, and the
    // set term is ORed last so a same-cycle event is never lost.
    always_ff @(posedge clk) begin
        if (!rst_n || hw_reset) begin
            fault_event_latch <= fflr_pkg::FAULT_EVENT_LATCH_RESET;
        end else if (done_pulse) begin
            fault_event_latch <= (fault_event_latch & ~report)
                                 | set_vec;
        end else begin
            fault_event_latch <= fault_event_latch | set_vec;
        end
    end

    // Snapshot offered to the link. Frozen while a transfer may load it,
    // one extra cycle covers skew between the two synchronised bits.
    always_ff @(posedge clk) begin
        if (!rst_n || hw_reset) begin
            report <= fflr_pkg::FAULT_EVENT_LATCH_RESET;
        end else if (!hold_s && !hold_d) begin
            report <= fault_event_latch & ~fflr_pkg::UNUSED_FIELD_MASK;
        end
    end

    // A start is SDA falling while SCL is high; the toggle is read by
    // the engine only on the following SCL rise, when it is stable.
    always_ff @(negedge sda_in or posedge link_clear_req) begin
        if (link_clear_req) begin
            start_tog <= 1'b0;
        end else if (scl) begin
            start_tog <= ~start_tog;
        end
    end

    assign rx_next = {shift[6:0], sda_in};

    // Serial engine: samples SDA on the rising edge of SCL.
    always_ff @(posedge scl or posedge link_clear_req) begin
        if (link_clear_req) begin
            state      <= fflr_pkg::LINK_IDLE;
            cnt        <= '0;
            shift      <= 8'h00;
            ptr        <= 8'h00;
            tx         <= 8'h00;
            ack_en     <= 1'b0;
            rw         <= 1'b0;
            hold       <= 1'b0;
            done_tog   <= 1'b0;
            start_seen <= 1'b0;
        end else if (start_tog != start_seen) begin
            // First address bit; freeze the snapshot well before loading.
            start_seen <= start_tog;
            state      <= fflr_pkg::LINK_ADDR;
            cnt        <= fflr_pkg::BIT_CNT_W'(1);
            shift      <= {7'h00, sda_in};
            ack_en     <= 1'b0;
            hold       <= 1'b1;
        end else begin
            if (state != fflr_pkg::LINK_IDLE) begin
                cnt <= (cnt == fflr_pkg::ACK_SLOT) ? '0 : cnt + 1'b1;
            end
            if (cnt != fflr_pkg::ACK_SLOT) begin
                shift <= rx_next;
            end
            if (cnt == fflr_pkg::LAST_BIT) begin
                rw     <= rx_next[0];
                ack_en <= (state == fflr_pkg::LINK_ADDR) ?
                          (rx_next[7:1] == DEV_ADDR) :
                          (state != fflr_pkg::LINK_RDATA);
            end
            if (cnt == fflr_pkg::ACK_SLOT) begin
                unique case (state)
                    fflr_pkg::LINK_IDLE: begin
                        state <= fflr_pkg::LINK_IDLE;
                    end
                    fflr_pkg::LINK_ADDR: begin
                        if (!ack_en) begin
                            state <= fflr_pkg::LINK_IDLE;
                            hold  <= 1'b0;
                        end else if (rw) begin
                            state <= fflr_pkg::LINK_RDATA;
                            tx    <= (ptr == fflr_pkg::FAULT_EVENT_LATCH_ADDR) ?
                                     report : 8'h00;
                        end else begin
                            state <= fflr_pkg::LINK_PTR;
                            hold  <= 1'b0;
                        end
                    end
                    fflr_pkg::LINK_PTR: begin
                        ptr   <= shift;
                        state <= fflr_pkg::LINK_WDATA;
                    end
                    fflr_pkg::LINK_WDATA: begin
                        state <= fflr_pkg::LINK_WDATA;
                    end
                    fflr_pkg::LINK_RDATA: begin
                        // Byte fully sent: ask the control side to clear.
                        if (ptr == fflr_pkg::FAULT_EVENT_LATCH_ADDR) begin
                            done_tog <= ~done_tog;
                        end
                        hold  <= 1'b0;
                        state <= fflr_pkg::LINK_IDLE;
                    end
                endcase
            end
        end
    end

    // Pin driver: changes on the falling edge of SCL, open drain only.
    always_ff @(negedge scl or posedge link_clear_req) begin
        if (link_clear_req) begin
            sda_pull <= 1'b0;
        end else begin
            sda_pull <= (cnt == fflr_pkg::ACK_SLOT && ack_en &&
                         state != fflr_pkg::LINK_RDATA &&
                         state != fflr_pkg::LINK_IDLE) ||
                        (state == fflr_pkg::LINK_RDATA &&
                         cnt != fflr_pkg::ACK_SLOT && !tx[~cnt[2:0]]);
        end
    end

    assign sda_out     = 1'b0;
    assign sda_drive_n = ~sda_pull;

    // Checks on the control clock domain.
    a_reset_clears: assert property (
        @(posedge clk) !rst_n |=> fault_event_latch == 8'h00)
        else $error("Fault register not zero after reset.");

    a_unused_zero: assert property (
        @(posedge clk) disable iff (!rst_n)
        (fault_event_latch[7:5] == 3'h0) && (report[7:5] == 3'h0))
        else $error("Unused fault register bits are set.");

    a_startup_latch: assert property (
        @(posedge clk) disable iff (!rst_n)
        events.startup_timeout && !hw_reset |=> fault_event_latch[4])
        else $error("Startup timeout event not latched in bit 4.");

    a_undervolt_latch: assert property (
        @(posedge clk) disable iff (!rst_n)
        events.input_undervoltage_lockout && !hw_reset
        |-> ##1 fault_event_latch[3] == 1'b1)
        else $error("Undervoltage event not latched in bit 3.");

    a_overtemp_latch: assert property (
        @(posedge clk) disable iff (!rst_n)
        $rose(events.over_temp) && !hw_reset
        |=> fault_event_latch[2] && !$past(fault_event_latch[2], 2) ||
            fault_event_latch[2])
        else $error("Over-temperature event not latched in bit 2.");

    a_short_latch: assert property (
        @(posedge clk) disable iff (!rst_n)
        events.output_short && !hw_reset |=> fault_event_latch[1])
        else $error("Output short event not latched in bit 1.");

    a_peak_persist: assert property (
        @(posedge clk) disable iff (!rst_n || hw_reset)
        events.peak_current [*8] |=> fault_event_latch[0])
        else $error("Continuous peak current not latched in bit 0.");

    a_peak_single: assert property (
        @(posedge clk) disable iff (!rst_n)
        $rose(fault_event_latch[0]) |-> $past(peak_run) == 4'h7)
        else $error("Peak current flag set without a continuous hit.");

    a_read_clears: assert property (
        @(posedge clk) disable iff (!rst_n)
        done_pulse && set_vec == 8'h00 && !hw_reset
        |=> (fault_event_latch & $past(report)) == 8'h00)
        else $error("Read did not clear the returned flags.");

    a_sticky_hold: assert property (
        @(posedge clk) disable iff (!rst_n)
        !done_pulse && !hw_reset
        |=> (fault_event_latch & $past(fault_event_latch)) ==
            $past(fault_event_latch))
        else $error("Flag dropped without a read.");

    a_set_wins: assert property (
        @(posedge clk) disable iff (!rst_n)
        done_pulse && !hw_reset
        |=> (fault_event_latch & $past(set_vec)) == $past(set_vec))
        else $error("Event lost during the clearing read.");

    a_hold_reset: assert property (
        @(posedge clk) disable iff (!rst_n)
        hw_reset |=> fault_event_latch == 8'h00 && report == 8'h00)
        else $error("Hold-low reset did not clear the register.");

endmodule : fflr_top

`default_nettype wire

// ===== design/fflr_pkg.sv
// Constants and types for the sticky fault event register block.
// Assumes one control clock at 10 MHz and a serial link clocked by SCL.
// Operation
// - Register resets to zero; bits 7 to 5 are unused and read zero.
// - A startup timeout fault sets bit 4 until cleared.
// - An input undervoltage lockout fault sets bit 3 until cleared.
// - A die over-temperature fault sets bit 2 until cleared.
// - An output short fault sets bit 1 until cleared.
// - A peak current limit held continuously, not momentarily, sets bit 0.
// - Every flag is cleared by the host reading the register.
// - SCL held low past the reset interval returns the register to default.
`default_nettype none

package fflr_pkg;

    // Register address on the serial link and its reset value.
    localparam logic [7:0] FAULT_EVENT_LATCH_ADDR  = 8'h01;
    localparam logic [7:0] FAULT_EVENT_LATCH_RESET = 8'h00;

    // Field positions inside the fault event register.
    localparam int BIT_STARTUP_TIMEOUT        = 4;
    localparam int BIT_INPUT_UNDERVOLTAGE     = 3;
    localparam int BIT_OVER_TEMP              = 2;
    localparam int BIT_OUTPUT_SHORT           = 1;
    localparam int BIT_PEAK_CURRENT           = 0;
    localparam logic [7:0] UNUSED_FIELD_MASK  = 8'hE0;

    // Seven-bit device address on the serial link.
    localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h20;

    // Hold-low reset interval, as a time and as control clock cycles.
    localparam int CLK_HZ          = 10_000_000;
    localparam int HW_RESET_MS     = 100;
    localparam int HW_RESET_CYCLES = (HW_RESET_MS * CLK_HZ) / 1000;
    localparam int LOW_CNT_W       = 21;

    // Cycles the peak current hit must persist to count as continuous.
    localparam int PEAK_PERSIST_CYCLES = 8;
    localparam int PEAK_CNT_W          = 4;

    // Bit counter width of the serial engine and the acknowledge slot.
    localparam int         BIT_CNT_W = 4;
    localparam logic [3:0] ACK_SLOT  = 4'h8;
    localparam logic [3:0] LAST_BIT  = 4'h7;

    // One-cycle fault events, and a peak current level that must persist, from the protection logic.
    typedef struct packed {
        logic startup_timeout;
        logic input_undervoltage_lockout;
        logic over_temp;
        logic output_short;
        logic peak_current;
    } fflr_evt_s;

    // Serial engine phases.
    typedef enum logic [2:0] {
        LINK_IDLE,
        LINK_ADDR,
        LINK_PTR,
        LINK_WDATA,
        LINK_RDATA
    } fflr_link_e;

endpackage : fflr_pkg

`default_nettype wire

// ===== design/fflr_sync.sv
// Two-stage level synchroniser, one chain per bit.
// Assumes each bit is a level or a toggle that is stable for many cycles.
`default_nettype none

module fflr_sync #(
    parameter int WIDTH = 1
) (
    // Destination clock.
    input  wire logic             clk,
    // Source levels and their synchronised copies.
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta;

    // No reset: the chain flushes itself within two edges.
    always_ff @(posedge clk) begin
        meta <= d;
        q    <= meta;
    end

endmodule : fflr_sync

`default_nettype wire

// ===== design/fflr_low_timer.sv
// Measures how long the serial clock line stays low.
// Assumes line_low is already synchronised to clk.
`default_nettype none

module fflr_low_timer #(
    parameter int CYCLES = fflr_pkg::HW_RESET_CYCLES
) (
    // Clock and reset.
    input  wire logic clk,
    input  wire logic rst_n,
    // Line state and timeout level.
    input  wire logic line_low,
    output logic      expired
);

    localparam logic [fflr_pkg::LOW_CNT_W-1:0] LIMIT =
        fflr_pkg::LOW_CNT_W'(CYCLES);

    logic [fflr_pkg::LOW_CNT_W-1:0] count;

    // Any high sample restarts the measurement.
    always_ff @(posedge clk) begin
        if (!rst_n || !line_low) begin
            count <= '0;
        end else if (count != LIMIT) begin
            count <= count + 1'b1;
        end
    end

    // Stays high until the line is released.
    always_ff @(posedge clk) begin
        if (!rst_n || !line_low) begin
            expired <= 1'b0;
        end else begin
            expired <= (count == LIMIT);
        end
    end

endmodule : fflr_low_timer

`default_nettype wire

// ===== verification/fflr_host.sv
// Host controller model driving the two-wire serial link.
// Assumes the bench resolves the open-drain data line with a pull-up.
`default_nettype none

module fflr_host (
    // Serial clock and host data drive, 1 meaning released.
    output logic      scl,
    output logic      sda_rel,
    // Resolved data line level.
    input  wire logic sda_line
);
    timeunit 1ns;
    timeprecision 10ps;

    // A quarter of the 125 ns link clock period.
    localparam realtime Q = 31.25;

    // The bus idles high and the clock stands still between frames.
    initial begin
        scl = 1'b1;
        sda_rel = 1'b1;
    end

    // Data changes mid-low; sampling a quarter after the rise is safe.
    task automatic bit_io(input logic b, output logic s);
        sda_rel = b;
        #Q scl = 1'b1;
        #Q s = sda_line;
        #Q scl = 1'b0;
        #Q;
    endtask : bit_io

    // Start, also serving as a repeated start.
    task automatic start_c;
        sda_rel = 1'b1;
        #Q scl = 1'b1;
        #Q sda_rel = 1'b0;
        #Q scl = 1'b0;
        #Q;
    endtask : start_c

    // Eight bits MSB first, then the acknowledge clock.
    task automatic byte_io(input logic [7:0] w, output logic [7:0] r,
                           output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(w[i], s);
            r[i] = s;
        end
        bit_io(1'b1, s);
        ack = ~s;
    endtask : byte_io

    // Pointer write, repeated start, one byte read, then a stop.
    task automatic read_reg(input logic [6:0] a, input logic [7:0] p,
                            output logic [7:0] d, output logic acked);
        logic [7:0] r;
        logic       a0;
        logic       a1;
        logic       a2;
        logic       a3;
        start_c();
        byte_io({a, 1'b0}, r, a0);
        byte_io(p, r, a1);
        start_c();
        byte_io({a, 1'b1}, r, a2);
        byte_io(8'hFF, d, a3); // Ends with a not-acknowledge.
        sda_rel = 1'b0;
        #Q scl = 1'b1;
        #Q sda_rel = 1'b1;
        #Q;
        acked = a0 & a1 & a2;
    endtask : read_reg

    // Pointer write and one data byte, which the device acknowledges.
    task automatic write_reg(input logic [6:0] a, input logic [7:0] p,
                             input logic [7:0] v, output logic acked);
        logic [7:0] r;
        logic       a0;
        logic       a1;
        logic       a2;
        start_c();
        byte_io({a, 1'b0}, r, a0);
        byte_io(p, r, a1);
        byte_io(v, r, a2);
        sda_rel = 1'b0;
        #Q scl = 1'b1;
        #Q sda_rel = 1'b1;
        #Q;
        acked = a0 & a1 & a2;
    endtask : write_reg

    // Clock pulses with data high, so no start is ever seen.
    task automatic pulses(input int n);
        repeat (n) begin
            #(2 * Q) scl = 1'b0;
            #(2 * Q) scl = 1'b1;
        end
    endtask : pulses

    // Hold the clock low for a number of 100 ns control cycles.
    task automatic hold_low(input int cycles);
        scl = 1'b0;
        #(cycles * 100) scl = 1'b1;
        #(4 * Q);
    endtask : hold_low

endmodule : fflr_host

`default_nettype wire

// ===== verification/fault_flag_latch_register_test.sv
// Self-checking bench for the sticky fault event register.
// Assumes the host model fflr_host and a shortened hold-low interval.
`default_nettype none

module fault_flag_latch_register_test;
    timeunit 1ns;
    timeprecision 100ps;

    // Hold-low interval shortened so the run stays brief.
    localparam int         HWR = 50;
    localparam logic [6:0] DEV = fflr_pkg::DEV_ADDR_DEFAULT;
    localparam logic [7:0] REG = fflr_pkg::FAULT_EVENT_LATCH_ADDR;

    logic                clk;
    logic                rst_n;
    fflr_pkg::fflr_evt_s events;
    logic                scl;
    logic                sda_rel;
    logic                sda_line;
    logic                sda_out;
    logic                sda_drive_n;
    logic                link_hw_reset;
    logic [7:0]          latch;
    logic [7:0]          rd;
    logic                ack;
    int                  err_count;
    int                  checks_done;

    fflr_top #(.HW_RESET_CYCLES(HWR)) dut_u (
        .clk(clk), .rst_n(rst_n), .events(events), .scl(scl),
        .sda_in(sda_line), .sda_out(sda_out), .sda_drive_n(sda_drive_n),
        .link_hw_reset(link_hw_reset), .fault_event_latch(latch));

    fflr_host host_u (.scl(scl), .sda_rel(sda_rel), .sda_line(sda_line));

    // Pull-up wins unless some party pulls the line low.
    assign sda_line = sda_rel & (sda_drive_n | sda_out);

    // Control clock at 10 MHz.
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Compare and count.
    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Verdict and end of run.
    task automatic tally_and_finish;
        if (err_count == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : tally_and_finish

    // Bounded wait on the hold-low reset level; running out ends the run.
    task automatic wait_for(input logic v, input int lim);
        for (int n = 0; n < lim && link_hw_reset !== v; n++) @(negedge clk);
        check("wait", {7'h00, link_hw_reset}, {7'h00, v});
        if (link_hw_reset !== v) tally_and_finish();
    endtask : wait_for

    // Hold events for n cycles, then sample after the last edge.
    task automatic drive(input logic [4:0] v, input int n);
        @(posedge clk);
        events <= v;
        repeat (n) @(posedge clk);
        events <= 5'h00;
        @(negedge clk);
    endtask : drive

    // The link side resets asynchronously on the registered clear level; scl still toggles meanwhile.
    task automatic do_reset;
        @(posedge clk);
        rst_n <= 1'b0;
        fork
            host_u.pulses(2);
            repeat (3) @(posedge clk);
        join
        @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(negedge clk);
    endtask : do_reset

    // Full read of the register; the clear lands a few cycles later.
    task automatic read_flags(input logic [7:0] exp);
        host_u.read_reg(DEV, REG, rd, ack);
        repeat (6) @(negedge clk);
        check("ack", {7'h00, ack}, 8'h01);
        check("read", rd, exp);
    endtask : read_flags

    // Each one-cycle event sets its own flag, which outlives the event.
    task automatic t_single;
        for (int b = 1; b <= 4; b++) begin
            drive(5'h01 << b, 1);
            repeat (3) @(negedge clk);
            check("flag", latch, 8'h01 << b);
            read_flags(8'h01 << b);
            check("cleared", latch, 8'h00);
        end
        drive(5'h1F, 8);
        check("all", latch, 8'h1F);
        do_reset();
        check("mid reset", latch, 8'h00);
    endtask : t_single

    // A momentary run of the peak event must not count.
    task automatic t_peak;
        drive(5'h01, 7);
        check("short run", latch, 8'h00);
        drive(5'h01, 8);
        check("long run", latch, 8'h01);
        read_flags(8'h01);
        check("cleared", latch, 8'h00);
    endtask : t_peak

    // A fault still present during the clearing read keeps its flag.
    task automatic t_set_wins;
        @(posedge clk);
        events <= 5'h04;
        read_flags(8'h04);
        check("held", latch, 8'h04);
        @(posedge clk);
        events <= 5'h00;
        read_flags(8'h04);
        check("cleared", latch, 8'h00);
    endtask : t_set_wins

    // A foreign address or another pointer leaves the flags alone.
    task automatic t_refused;
        drive(5'h08, 1);
        host_u.read_reg(DEV ^ 7'h01, REG, rd, ack);
        repeat (6) @(negedge clk);
        check("nak", {7'h00, ack}, 8'h00);
        check("float", rd, 8'hFF);
        check("kept", latch, 8'h08);
        host_u.read_reg(DEV, 8'h00, rd, ack);
        repeat (6) @(negedge clk);
        check("other", rd, 8'h00);
        check("kept", latch, 8'h08);
        host_u.write_reg(DEV, REG, 8'hFF, ack);
        repeat (6) @(negedge clk);
        check("write ack", {7'h00, ack}, 8'h01);
        check("kept", latch, 8'h08);
        read_flags(8'h08);
    endtask : t_refused

    // Holding the serial clock low past the interval wipes the register.
    task automatic t_hwreset;
        drive(5'h1E, 1);
        fork
            host_u.hold_low(HWR + 30);
            begin
                wait_for(1'b1, HWR + 20);
                @(negedge clk);
                check("wiped", latch, 8'h00);
                drive(5'h1F, 1);
                check("refused", latch, 8'h00);
            end
        join
        wait_for(1'b0, 20);
        // The link reset drops a cycle later, so the link stays idle a while.
        repeat (2) @(negedge clk);
        read_flags(8'h00);
    endtask : t_hwreset

    // Main sequence.
    initial begin
        rst_n = 1'b0;
        events = 5'h00;
        err_count = 0;
        checks_done = 0;
        do_reset();
        check("reset", latch, fflr_pkg::FAULT_EVENT_LATCH_RESET);
        read_flags(8'h00);
        t_single();
        t_peak();
        t_set_wins();
        t_refused();
        t_hwreset();
        tally_and_finish();
    end

endmodule : fault_flag_latch_register_test

`default_nettype wire
